// File: bench/embpc_mem_model.sv
// Far side: address latch and pin pads with outside pull-downs
`timescale 1ns/1ps
module embpc_mem_model (
  input wire logic clock, addrLatchStrobe, // timing
  input wire logic [7:0] p2Out, p3Out, p3Oe, p3WeakPullup, p4Out, p4Oe, p4WeakPullup, // pads
  input wire logic [7:0] p3Ext, p4Ext, // a one pulls that pin low
  output logic [7:0] p3In, p4In, latchedHigh // pin levels, latched byte
);
  logic flip_q = 1'b0;
  // A floating pin toggles so it never passes for data
  always_ff @(posedge clock) flip_q <= ~flip_q;
  function automatic logic [7:0] padLevel(input logic [7:0] o, oe, wk, ext);
    return (oe & o) | (~oe & ~ext & (wk | {8{flip_q}}));
  endfunction
  always_comb begin
    p3In = padLevel(p3Out, p3Oe, p3WeakPullup, p3Ext);
    p4In = padLevel(p4Out, p4Oe, p4WeakPullup, p4Ext);
  end
  always_ff @(negedge addrLatchStrobe) latchedHigh <= p2Out;
endmodule

// File: bench/embpc_port_control_asserts.sv
// Checker for the bus and port control pins
`timescale 1ns/1ps
module embpc_port_control_asserts (
  input wire logic clock, rstn, resetPinN, deviceReset, serialTxEnable, // control
  input wire logic addrLatchStrobe, dataAccessWide, dataAccessNarrow, progVerify, // timing
  input wire logic serialTxd, writeStrobeN, readStrobeN, // alternates
  input wire logic [7:0] addrHigh, portThreeRegister, p4In, p2Out, p2Oe, p3Out, lowAddrVerify // bytes
);
  logic [5:0] lowCnt_q;
  logic acc;
  assign acc = dataAccessWide || dataAccessNarrow;
  // Raw pin count, so the two synchroniser edges sit inside the figures below
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) lowCnt_q <= 6'h00;
    else if (resetPinN) lowCnt_q <= 6'h00;
    else if (lowCnt_q != 6'h3F) lowCnt_q <= lowCnt_q + 6'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn || deviceReset);
  a_strobe_gap: assert property ($rose(addrLatchStrobe) |-> ##1 addrLatchStrobe ##1 !addrLatchStrobe [*4])
    else $error("strobe shape");
  a_strobe_regular: assert property ($rose(addrLatchStrobe) ##1 !acc [*6] |-> $rose(addrLatchStrobe))
    else $error("strobe missing");
  a_strobe_skip: assert property (acc ##1 (acc && $rose(addrLatchStrobe)) ##1 acc [*6] |-> !$rose(addrLatchStrobe))
    else $error("strobe not skipped");
  a_port2_wide: assert property (dataAccessWide |=> p2Out == $past(addrHigh) && p2Oe == 8'hFF)
    else $error("port 2 address");
  a_port3_alt: assert property (
    1'b1 |=> p3Out == $past(portThreeRegister & {readStrobeN, writeStrobeN, 4'hF, serialTxd, 1'b1}))
    else $error("port 3 drive");
  a_verify_addr: assert property (progVerify && $past(progVerify) |-> lowAddrVerify == $past(p4In, 3))
    else $error("verify address");
  a_reset_qualify: assert property (disable iff (!rstn) lowCnt_q == 6'h2A |-> deviceReset)
    else $error("reset not taken");
  a_reset_hold: assert property (disable iff (!rstn) deviceReset && $past(deviceReset) |-> addrLatchStrobe && !serialTxEnable)
    else $error("reset outputs");
  cover property (disable iff (!rstn) $rose(deviceReset));
  cover property (dataAccessWide && $rose(addrLatchStrobe));
  cover property (progVerify && $past(progVerify));
endmodule
bind embpc_port_control embpc_port_control_asserts chk (.*);

// File: bench/embpc_port_control_tb.sv
// Self-checking bench for the bus and port control block
`timescale 1ns/1ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin badCount++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module embpc_port_control_tb;
  logic clock = 1'b0, rstn = 1'b0, resetPinN = 1'b1, progVerify = 1'b0;
  logic fetchExternal = 1'b0, dataAccessWide = 1'b0, dataAccessNarrow = 1'b0;
  logic serialTxd = 1'b1, writeStrobeN = 1'b1, readStrobeN = 1'b1;
  logic [7:0] addrHigh = 8'h00, portTwoRegister = 8'hFF, portThreeRegister = 8'hFF, portFourRegister = 8'hFF;
  logic [7:0] p3Ext = 8'h00, p4Ext = 8'h00, p3In, p4In, latchedHigh, p2Out, p2Oe, p2WeakPullup, p3Out, p3Oe;
  logic [7:0] p3WeakPullup, p4Out, p4Oe, p4WeakPullup, p3InSync, lowAddrVerify;
  logic addrLatchStrobe, serialRxd, extInterruptZero, extInterruptOne, timerZeroCountIn, timerOneCountIn;
  logic deviceReset, serialTxEnable;
  logic [31:0] rng = 32'h2CA5;
  logic [39:0] notes[$], note;
  int badCount = 0, samplesChecked = 0, rises = 0;
  always #2 clock = ~clock;
  embpc_port_control DUT (.*);
  embpc_mem_model model (.*);
  always @(posedge addrLatchStrobe) rises++;
  function automatic logic [31:0] nextRand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // Access kind holds for one machine cycle, data bytes change every cycle
  task automatic traffic(int mcs);
    logic [31:0] r;
    logic addr;
    repeat (mcs) begin
      r = nextRand();
      repeat (12) begin
        @(negedge clock);
        {dataAccessWide, dataAccessNarrow, fetchExternal, serialTxd, writeStrobeN, readStrobeN} = r[5:0];
        void'(nextRand());
        {portFourRegister, addrHigh, portTwoRegister, portThreeRegister} = rng;
        addr = dataAccessWide || (!dataAccessNarrow && fetchExternal);
        notes.push_back({addr ? addrHigh : portTwoRegister, addr ? 8'hFF : ~portTwoRegister,
          addr ? 8'h00 : portTwoRegister,
          portThreeRegister & {readStrobeN, writeStrobeN, 4'hF, serialTxd, 1'b1}, portFourRegister});
      end
    end
  endtask
  task automatic testDone();
    $display("checked %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) begin
    #1;
    if (notes.size() > 0) begin
      note = notes.pop_front();
      `CHK(p2Out, note[39:32])
      `CHK(p2Oe, note[31:24])
      `CHK(p2WeakPullup, note[23:16])
      `CHK(p3Out, note[15:8])
      `CHK(p3Oe, ~note[15:8])
      `CHK(p3WeakPullup, note[15:8])
      `CHK(p4Out, note[7:0])
      `CHK(p4Oe, ~note[7:0])
      `CHK(p4WeakPullup, note[7:0])
    end
  end
  initial begin
    repeat (3000) @(posedge clock);
    badCount++;
    testDone();
  end
  initial begin
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    traffic(25);
    @(negedge clock);
    {dataAccessWide, dataAccessNarrow, fetchExternal} = 3'b000;
    repeat (12) @(negedge clock);
    rises = 0;
    repeat (120) @(negedge clock);
    `CHK(rises, 20)
    dataAccessWide = 1'b1;
    repeat (12) @(negedge clock);
    rises = 0;
    repeat (120) @(negedge clock);
    `CHK(rises, 10)
    dataAccessWide = 1'b0;
    portThreeRegister = 8'hFF;
    {serialTxd, writeStrobeN, readStrobeN} = 3'b111;
    progVerify = 1'b1;
    void'(nextRand());
    {p4Ext, p3Ext} = rng[15:0];
    repeat (6) @(negedge clock);
    `CHK(lowAddrVerify, ~p4Ext)
    `CHK(p4Oe, 8'h00)
    `CHK(extInterruptZero, ~p3Ext[2])
    `CHK(p3InSync, ~p3Ext)
    `CHK({serialRxd, extInterruptOne, timerZeroCountIn, timerOneCountIn}, ~{p3Ext[0], p3Ext[3], p3Ext[4], p3Ext[5]})
    `CHK(p4WeakPullup, 8'hFF)
    progVerify = 1'b0;
    fetchExternal = 1'b1;
    addrHigh = 8'h5A;
    repeat (14) @(negedge clock);
    `CHK(latchedHigh, 8'h5A)
    // Two machine cycles low is too short to count as a reset
    resetPinN = 1'b0;
    repeat (24) @(negedge clock);
    resetPinN = 1'b1;
    repeat (4) @(negedge clock);
    `CHK(deviceReset, 1'b0)
    resetPinN = 1'b0; // held well past three machine cycles
    repeat (44) @(negedge clock);
    `CHK(deviceReset, 1'b1)
    `CHK(addrLatchStrobe, 1'b1)
    `CHK(p2Oe, 8'h00)
    `CHK(serialTxEnable, 1'b0)
    repeat (8) @(negedge clock);
    `CHK(serialTxEnable, 1'b0)
    resetPinN = 1'b1;
    repeat (8) @(negedge clock);
    `CHK(deviceReset, 1'b0)
    testDone();
  end
endmodule

// File: hdl/embpc_pkg.sv
// Constants for the external memory bus and port control block
package embpc_pkg;
  localparam int unsigned OSC_PER_MACHINE_CYCLE = 12;
  localparam int unsigned RESET_MACHINE_CYCLES = 3;
  localparam int unsigned RESET_QUAL_CYCLES = RESET_MACHINE_CYCLES * OSC_PER_MACHINE_CYCLE;
  localparam int unsigned SERIAL_TX_MAX_MACHINE_CYCLES = 4;
  localparam int unsigned SERIAL_TX_MAX_CYCLES = SERIAL_TX_MAX_MACHINE_CYCLES * OSC_PER_MACHINE_CYCLE;
  localparam int unsigned PHASE_W = 4;
  localparam int unsigned QUAL_W = 6;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(OSC_PER_MACHINE_CYCLE - 1);
  localparam logic [PHASE_W-1:0] ALE_FIRST_START = 4'h0;
  localparam logic [PHASE_W-1:0] ALE_FIRST_END = 4'h1;
  localparam logic [PHASE_W-1:0] ALE_SECOND_START = 4'h6;
  localparam logic [PHASE_W-1:0] ALE_SECOND_END = 4'h7;
  localparam logic [7:0] PORT_RESET_VALUE = 8'hFF;
  localparam int unsigned P3_RXD = 0;
  localparam int unsigned P3_TXD = 1;
  localparam int unsigned P3_EXT_INTERRUPT_ZERO = 2;
  localparam int unsigned P3_EXT_INTERRUPT_ONE = 3;
  localparam int unsigned P3_T0 = 4;
  localparam int unsigned P3_T1 = 5;
  localparam int unsigned P3_WR = 6;
  localparam int unsigned P3_RD = 7;
  typedef enum logic [1:0] {P2_PORT, P2_ADDR_WEAK, P2_ADDR_STRONG} embpc_p2src_type;
endpackage

// File: hdl/embpc_port_control.sv
// External memory bus timing and port 2, 3 and 4 pin control
// Function
// [RULE1] Latched ones drive only weak pull-up
// [RULE2] Port 2 carries high address on fetch
// [RULE3] 16-bit data access: strong high address byte
// [RULE4] 8-bit data access: port 2 keeps register
// [RULE5] Port 3 carries optional alternate functions
// [RULE6] Port 4 takes low address in verification
// [RULE7] Reset after three machine cycles low
// [RULE8] Serial channel stops within four machine cycles
// [RULE9] Address latch strobe marks low address byte
// [RULE10] Strobe pulses at one sixth oscillator rate
// [RULE11] One strobe skipped per data access
// [RULE12] Strobe held high during reset
// [RULE13] Machine cycle is twelve oscillator periods
`timescale 1ns/1ps
module embpc_port_control (
  input wire logic clock, // Oscillator clock, 250 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic resetPinN, // Device reset pin, active low
  input wire logic fetchExternal, // Core fetches from external program memory
  input wire logic dataAccessWide, // Data access with 16-bit address
  input wire logic dataAccessNarrow, // Data access with 8-bit index register address
  input wire logic [7:0] addrHigh, // High address byte from core
  input wire logic [7:0] portTwoRegister, // Port 2 output register
  input wire logic [7:0] portThreeRegister, // Port 3 output register
  input wire logic [7:0] portFourRegister, // Port 4 output register
  input wire logic serialTxd, // Serial transmit data from core
  input wire logic writeStrobeN, // Data memory write strobe from core
  input wire logic readStrobeN, // Data memory read strobe from core
  input wire logic progVerify, // Program verification mode
  input wire logic [7:0] p3In, // Port 3 pin levels
  input wire logic [7:0] p4In, // Port 4 pin levels
  output logic addrLatchStrobe, // Address latch strobe pin
  output logic [7:0] p2Out, // Port 2 drive level
  output logic [7:0] p2Oe, // Port 2 strong drive enable
  output logic [7:0] p2WeakPullup, // Port 2 weak pull-up enable
  output logic [7:0] p3Out, // Port 3 drive level
  output logic [7:0] p3Oe, // Port 3 drive enable
  output logic [7:0] p3WeakPullup, // Port 3 weak pull-up enable
  output logic [7:0] p4Out, // Port 4 drive level
  output logic [7:0] p4Oe, // Port 4 drive enable
  output logic [7:0] p4WeakPullup, // Port 4 weak pull-up enable
  output logic [7:0] p3InSync, // Port 3 pins after synchroniser
  output logic [7:0] lowAddrVerify, // Low address byte in verification
  output logic serialRxd, // Serial receive input
  output logic extInterruptZero, // External interrupt 0 input
  output logic extInterruptOne, // External interrupt 1 input
  output logic timerZeroCountIn, // Timer 0 count input
  output logic timerOneCountIn, // Timer 1 count input
  output logic deviceReset, // Qualified internal reset
  output logic serialTxEnable // Serial channel transmit permit
);
  logic resetActive;
  logic [embpc_pkg::PHASE_W-1:0] phaseQ;
  logic skipSecondQ;
  logic aleQ;
  logic aleD;
  embpc_pkg::embpc_p2src_type p2Src;
  logic [7:0] p2OutQ, p2OeQ, p2WeakQ;
  logic [7:0] p3OutQ, p3OeQ, p3WeakQ;
  logic [7:0] p4OutQ, p4OeQ, p4WeakQ;
  logic [7:0] p3Sync1Q, p3Sync2Q;
  logic [7:0] p4Sync1Q, p4Sync2Q;
  logic [7:0] lowAddrQ;
  logic [7:0] p3Alt;

  embpc_reset_qual resetQual (
    .clock(clock),
    .rstn(rstn),
    .resetPinN(resetPinN),
    .resetActive(resetActive),
    .serialTxEnable(serialTxEnable)
  );

  // Quasi-bidirectional pin: strong low for a zero, weak pull-up for a one
  function automatic logic [1:0] quasiPin(input logic level);
    quasiPin = level ? 2'h1 : 2'h2; // [RULE1]
  endfunction

  // Machine-cycle phase counter, twelve oscillator periods per cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phaseQ <= '0;
    end else if (resetActive || phaseQ == embpc_pkg::PHASE_LAST) begin
      phaseQ <= '0; // [RULE13]
    end else begin
      phaseQ <= phaseQ + 1'b1;
    end
  end

  // A data access is flagged by the core before the second strobe slot
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      skipSecondQ <= 1'b0;
    end else if (phaseQ == embpc_pkg::ALE_FIRST_START) begin
      skipSecondQ <= 1'b0;
    end else if (phaseQ < embpc_pkg::ALE_SECOND_START && (dataAccessWide || dataAccessNarrow)) begin
      skipSecondQ <= 1'b1; // [RULE11]
    end
  end

  always_comb begin
    aleD = 1'b0;
    if (resetActive) begin
      aleD = 1'b1; // [RULE12]
    end else if (phaseQ == embpc_pkg::PHASE_LAST || phaseQ == embpc_pkg::ALE_FIRST_START) begin
      aleD = 1'b1; // [RULE10] [RULE9]
    end else if (phaseQ == embpc_pkg::ALE_SECOND_START) begin
      // A late access must not cut a pulse already begun down to one cycle
      aleD = aleQ; // [RULE10]
    end else if (phaseQ == embpc_pkg::ALE_SECOND_START - 1'b1
                 && !skipSecondQ && !dataAccessWide && !dataAccessNarrow) begin
      aleD = 1'b1; // [RULE10] [RULE11]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aleQ <= 1'b1;
    end else begin
      aleQ <= aleD;
    end
  end

  always_comb begin
    if (dataAccessWide) begin
      p2Src = embpc_pkg::P2_ADDR_STRONG; // [RULE3]
    end else if (dataAccessNarrow) begin
      p2Src = embpc_pkg::P2_PORT; // [RULE4]
    end else if (fetchExternal) begin
      p2Src = embpc_pkg::P2_ADDR_STRONG; // [RULE2]
    end else begin
      p2Src = embpc_pkg::P2_PORT;
    end
  end

  // Per-pin drive; ports return to all ones with weak pull-ups in reset
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : gPin
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          p2OutQ[i] <= embpc_pkg::PORT_RESET_VALUE[i];
          p2OeQ[i] <= 1'b0;
          p2WeakQ[i] <= 1'b1;
        end else if (resetActive) begin
          p2OutQ[i] <= embpc_pkg::PORT_RESET_VALUE[i];
          p2OeQ[i] <= 1'b0;
          p2WeakQ[i] <= 1'b1;
        end else if (p2Src == embpc_pkg::P2_ADDR_STRONG) begin
          p2OutQ[i] <= addrHigh[i]; // [RULE2] [RULE3]
          p2OeQ[i] <= 1'b1;
          p2WeakQ[i] <= 1'b0;
        end else begin
          p2OutQ[i] <= portTwoRegister[i]; // [RULE4]
          {p2OeQ[i], p2WeakQ[i]} <= quasiPin(portTwoRegister[i]); // [RULE1]
        end
      end

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          p3OutQ[i] <= embpc_pkg::PORT_RESET_VALUE[i];
          p3OeQ[i] <= 1'b0;
          p3WeakQ[i] <= 1'b1;
        end else if (resetActive) begin
          p3OutQ[i] <= embpc_pkg::PORT_RESET_VALUE[i];
          p3OeQ[i] <= 1'b0;
          p3WeakQ[i] <= 1'b1;
        end else begin
          p3OutQ[i] <= portThreeRegister[i] & p3Alt[i]; // [RULE5]
          {p3OeQ[i], p3WeakQ[i]} <= quasiPin(portThreeRegister[i] & p3Alt[i]); // [RULE1]
        end
      end

      // Verification mode releases port 4 so the address can come in
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          p4OutQ[i] <= embpc_pkg::PORT_RESET_VALUE[i];
          p4OeQ[i] <= 1'b0;
          p4WeakQ[i] <= 1'b1;
        end else if (resetActive || progVerify) begin
          p4OutQ[i] <= embpc_pkg::PORT_RESET_VALUE[i]; // [RULE6]
          p4OeQ[i] <= 1'b0;
          p4WeakQ[i] <= 1'b1;
        end else begin
          p4OutQ[i] <= portFourRegister[i];
          {p4OeQ[i], p4WeakQ[i]} <= quasiPin(portFourRegister[i]); // [RULE1]
        end
      end
    end
  endgenerate

  // Alternate outputs gate the latch; unused alternate slots stay high
  always_comb begin
    p3Alt = embpc_pkg::PORT_RESET_VALUE;
    p3Alt[embpc_pkg::P3_TXD] = serialTxd; // [RULE5]
    p3Alt[embpc_pkg::P3_WR] = writeStrobeN; // [RULE5]
    p3Alt[embpc_pkg::P3_RD] = readStrobeN; // [RULE5]
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      p3Sync1Q <= embpc_pkg::PORT_RESET_VALUE;
      p3Sync2Q <= embpc_pkg::PORT_RESET_VALUE;
      p4Sync1Q <= embpc_pkg::PORT_RESET_VALUE;
      p4Sync2Q <= embpc_pkg::PORT_RESET_VALUE;
    end else begin
      p3Sync1Q <= p3In;
      p3Sync2Q <= p3Sync1Q;
      p4Sync1Q <= p4In;
      p4Sync2Q <= p4Sync1Q;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lowAddrQ <= '0;
    end else if (progVerify) begin
      lowAddrQ <= p4Sync2Q; // [RULE6]
    end
  end

  assign addrLatchStrobe = aleQ;
  assign p2Out = p2OutQ;
  assign p2Oe = p2OeQ;
  assign p2WeakPullup = p2WeakQ;
  assign p3Out = p3OutQ;
  assign p3Oe = p3OeQ;
  assign p3WeakPullup = p3WeakQ;
  assign p4Out = p4OutQ;
  assign p4Oe = p4OeQ;
  assign p4WeakPullup = p4WeakQ;
  assign p3InSync = p3Sync2Q;
  assign lowAddrVerify = lowAddrQ;
  assign serialRxd = p3Sync2Q[embpc_pkg::P3_RXD]; // [RULE5]
  assign extInterruptZero = p3Sync2Q[embpc_pkg::P3_EXT_INTERRUPT_ZERO];
  assign extInterruptOne = p3Sync2Q[embpc_pkg::P3_EXT_INTERRUPT_ONE];
  assign timerZeroCountIn = p3Sync2Q[embpc_pkg::P3_T0];
  assign timerOneCountIn = p3Sync2Q[embpc_pkg::P3_T1];
  assign deviceReset = resetActive; // [RULE7]
endmodule

// File: hdl/embpc_reset_qual.sv
// Reset pin synchroniser and machine-cycle qualifier
`timescale 1ns/1ps
module embpc_reset_qual (
  input wire logic clock, // Oscillator clock
  input wire logic rstn, // Power-on reset of the logic
  input wire logic resetPinN, // Reset pin, asynchronous
  output logic resetActive, // Qualified device reset
  output logic serialTxEnable // Serial channel may still transmit
);
  logic sync1Q, sync2Q;
  logic [embpc_pkg::QUAL_W-1:0] lowCountQ;
  logic resetActiveQ, serialTxQ;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1Q <= 1'b1;
      sync2Q <= 1'b1;
    end else begin
      sync1Q <= resetPinN;
      sync2Q <= sync1Q;
    end
  end

  // Glitches shorter than the qualifying time restart the count
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lowCountQ <= '0;
    end else if (sync2Q) begin
      lowCountQ <= '0;
    end else if (lowCountQ != embpc_pkg::QUAL_W'(embpc_pkg::RESET_QUAL_CYCLES)) begin
      lowCountQ <= lowCountQ + 1'b1; // [RULE7] [RULE13]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      resetActiveQ <= 1'b1;
    end else if (sync2Q) begin
      resetActiveQ <= 1'b0;
    end else if (lowCountQ == embpc_pkg::QUAL_W'(embpc_pkg::RESET_QUAL_CYCLES - 1)) begin
      resetActiveQ <= 1'b1; // [RULE7]
    end
  end

  // Transmit is stopped when reset is recognised, well inside the four-cycle limit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      serialTxQ <= 1'b0;
    end else begin
      serialTxQ <= !(resetActiveQ || (!sync2Q && lowCountQ == embpc_pkg::QUAL_W'(embpc_pkg::RESET_QUAL_CYCLES - 1)));
    end
  end

  assign resetActive = resetActiveQ;
  assign serialTxEnable = serialTxQ; // [RULE8]
endmodule
